/* rtl/siu_map.svh */
// Constants for the system instruction unit: opcodes, selectors, field positions and reset values
`ifndef SIU_MAP_SVH
`define SIU_MAP_SVH

// Operation codes on req.op
`define SIU_OP_NONE      4'h0
`define SIU_OP_DMB       4'h1
`define SIU_OP_DSB       4'h2
`define SIU_OP_ISB       4'h3
`define SIU_OP_MFS       4'h4
`define SIU_OP_MTS       4'h5
`define SIU_OP_NOP       4'h6
`define SIU_OP_SEV       4'h7
`define SIU_OP_SVC       4'h8
`define SIU_OP_WFE       4'h9
`define SIU_OP_WFI       4'ha
`define SIU_OP_IRQ_DISABLE_OP     4'hb
`define SIU_OP_CPSIE     4'hc

// Special register selectors on spec_sel
`define SIU_SR_APP_STATUS_VIEW      4'h0
`define SIU_SR_IAPSR     4'h1
`define SIU_SR_EAPSR     4'h2
`define SIU_SR_PSR       4'h3
`define SIU_SR_EXCEPTION_NUMBER_VIEW      4'h5
`define SIU_SR_EXECUTION_STATUS_VIEW      4'h6
`define SIU_SR_IEPSR     4'h7
`define SIU_SR_MSP       4'h8
`define SIU_SR_PSP       4'h9
`define SIU_SR_INTERRUPT_MASK_BIT   4'ha
`define SIU_SR_CONTROL   4'hb

// Field positions
`define SIU_FLAGS_HI     31
`define SIU_FLAGS_LO     28
`define SIU_EXC_HI       5
`define SIU_EXC_LO       0
`define SIU_TBIT         24
`define SIU_CTRL_HI      1
`define SIU_CTRL_LO      0

// Reset values
`define SIU_RST_FLAGS    4'h0
`define SIU_RST_WORD     32'h0000_0000
`define SIU_RST_EXECUTION_STATUS_VIEW     32'h0100_0000
`define SIU_RST_CTRL     2'h0

`endif

/* rtl/siu_pkg.sv */
// Types for the system instruction unit
package siu_pkg;

    typedef struct packed {
        logic        valid;
        logic [3:0]  op;
        logic [3:0]  spec_sel;
        logic [31:0] src_val;
        logic [7:0]  imm;
    } siu_req_t;

    typedef struct packed {
        logic        wr_en;
        logic [31:0] wr_val;
    } siu_gpr_wr_t;

    typedef struct packed {
        logic exc_taken;
        logic irq_pend_preempt;
        logic new_pending;
        logic dbg_req;
        logic dbg_en;
        logic ext_event;
    } siu_wake_t;

    typedef enum logic [4:0] {
        SIU_IDLE     = 5'b00001,
        SIU_DRAIN    = 5'b00010,
        SIU_FLUSH    = 5'b00100,
        SIU_SLEEP_I  = 5'b01000,
        SIU_SLEEP_E  = 5'b10000
    } siu_state_t;

endpackage : siu_pkg

/* rtl/siu_system_instr_unit.sv */
// System and miscellaneous instruction execution unit
//
// Behaviour
// [RULE_01] Data memory barrier: earlier memory accesses observed before later ones.
// [RULE_02] Data memory barrier never stalls instructions that do not touch memory; here it stalls all while accesses are outstanding.
// [RULE_03] After data sync barrier, later instructions wait until the barrier completes.
// [RULE_04] Data sync barrier completes once all earlier memory accesses finished.
// [RULE_05] Instruction sync barrier flushes pipeline; later instructions refetched afterwards.
// [RULE_06] Move-from-special copies status views, stack pointers, mask or control to destination.
// [RULE_07] Software never names stack pointer or program counter as move-from destination.
// [RULE_08] Move-to-special writes the source register value into the chosen special register.
// [RULE_09] Software never uses stack pointer or program counter as move-to source.
// [RULE_10] Move-to a status view sets condition flags straight from source bits.
// [RULE_11] Barriers, no-op, send-event, supervisor call and waits leave flags unchanged.
// [RULE_12] No-operation may be dropped and takes no time; usable as padding.
// [RULE_13] Send-event signals all processors and sets the local event register.
// [RULE_14] Supervisor call raises its exception; the 8-bit immediate is ignored.
// [RULE_15] Wait-for-event unimplemented here unless enabled; it may act as no-operation.
// [RULE_16] Implemented wait-for-event sleeps while event register zero until a wake source.
// [RULE_17] Implemented wait-for-event with event register set clears it and completes.
// [RULE_18] Wait-for-interrupt sleeps until exception, preempting pending irq, or debug request.
// [RULE_19] Software treats wait-for-interrupt as a hint that may complete at once.
// [RULE_20] Interrupt mask set by disable, cleared by enable; blocks all but non-maskable.
// [RULE_21] A woken wait resumes at the next instruction after any waking exception.
`include "siu_map.svh"
`timescale 1ns/100ps
`default_nettype none

module siu_system_instr_unit
#(
    parameter bit WFE_IMPL = 1'b0
)
(
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    input  wire siu_pkg::siu_req_t    req,
    input  wire logic                 mem_outstanding,
    input  wire siu_pkg::siu_wake_t   wake_in,
    input  wire logic [5:0]           exc_number,
    input  wire logic                 sp_sel_msp,
    output logic                      req_ready,
    output logic                      done,
    output siu_pkg::siu_gpr_wr_t      gpr_wr,
    output logic                      mem_order_fence,
    output logic                      pipe_flush,
    output logic                      svc_raise,
    output logic                      event_out,
    output logic                      sleeping,
    output logic [3:0]                flags,
    output logic                      interrupt_mask_bit,
    output logic [1:0]                control,
    output logic [31:0]               main_stack_ptr,
    output logic [31:0]               process_stack_ptr,
    output logic                      event_reg
);
    import siu_pkg::*;

    logic        rst_meta_reg;
    logic        rst_sync_reg;
    logic        rst_n;
    logic [5:0]  wake_meta_reg;
    logic [5:0]  wake_sync_reg;
    siu_wake_t   wk;
    siu_state_t  state_reg;
    siu_state_t  state_next;
    logic        take;
    logic        wake_i;
    logic        wake_e;
    logic [31:0] psr_full;
    logic [31:0] mfs_val;

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    // Wake sources come from other blocks' pins
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake_meta_reg <= 6'h00;
            wake_sync_reg <= 6'h00;
        end
        else
        begin
            wake_meta_reg <= wake_in;
            wake_sync_reg <= wake_meta_reg;
        end
    end
    assign wk = siu_wake_t'(wake_sync_reg);

    function automatic logic is_status_view(input logic [3:0] sel);
        is_status_view = (sel[3:2] == 2'b00) && (sel != 4'h4) || (sel[3:2] == 2'b01);
    endfunction : is_status_view

    function automatic logic has_app_flags(input logic [3:0] sel);
        has_app_flags = (sel == `SIU_SR_APP_STATUS_VIEW) || (sel == `SIU_SR_IAPSR)
                     || (sel == `SIU_SR_EAPSR) || (sel == `SIU_SR_PSR);
    endfunction : has_app_flags

    assign take   = req.valid && req_ready;
    // Mask does not gate the wait-for-interrupt wake
    assign wake_i = wk.exc_taken || wk.irq_pend_preempt || wk.dbg_req; // [RULE_18]
    assign wake_e = (wk.exc_taken && !interrupt_mask_bit) || wk.new_pending
                 || (wk.dbg_req && wk.dbg_en) || wk.ext_event; // [RULE_16]

    assign psr_full = {flags, 3'h0, 1'b1, 18'h0, exc_number};

    always_comb
    begin
        mfs_val = `SIU_RST_WORD;
        case (req.spec_sel) // [RULE_06]
            `SIU_SR_APP_STATUS_VIEW:    mfs_val = {flags, 28'h0};
            `SIU_SR_EXCEPTION_NUMBER_VIEW:    mfs_val = {26'h0, exc_number};
            `SIU_SR_EXECUTION_STATUS_VIEW:    mfs_val = `SIU_RST_WORD;
            `SIU_SR_IAPSR:   mfs_val = {flags, 22'h0, exc_number};
            `SIU_SR_EAPSR:   mfs_val = {flags, 28'h0};
            `SIU_SR_IEPSR:   mfs_val = {26'h0, exc_number};
            `SIU_SR_PSR:     mfs_val = {psr_full[31:25], 1'b0, psr_full[23:0]};
            `SIU_SR_MSP:     mfs_val = main_stack_ptr;
            `SIU_SR_PSP:     mfs_val = process_stack_ptr;
            `SIU_SR_INTERRUPT_MASK_BIT: mfs_val = {31'h0, interrupt_mask_bit};
            `SIU_SR_CONTROL: mfs_val = {30'h0, control};
            default:         mfs_val = `SIU_RST_WORD;
        endcase
    end

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            SIU_IDLE:
            begin
                if (take)
                begin
                    case (req.op)
                        `SIU_OP_DSB: state_next = SIU_DRAIN; // [RULE_03]
                        `SIU_OP_DMB: state_next = mem_outstanding ? SIU_DRAIN : SIU_IDLE; // [RULE_01]
                        `SIU_OP_ISB: state_next = SIU_FLUSH; // [RULE_05]
                        `SIU_OP_WFI: state_next = SIU_SLEEP_I; // [RULE_18]
                        `SIU_OP_WFE:
                            if (WFE_IMPL && !event_reg) // [RULE_15] [RULE_17]
                                state_next = SIU_SLEEP_E; // [RULE_16]
                        default:     state_next = SIU_IDLE;
                    endcase
                end
            end
            SIU_DRAIN:   if (!mem_outstanding) state_next = SIU_IDLE; // [RULE_04]
            SIU_FLUSH:   state_next = SIU_IDLE;
            SIU_SLEEP_I: if (wake_i) state_next = SIU_IDLE; // [RULE_21]
            SIU_SLEEP_E: if (wake_e) state_next = SIU_IDLE; // [RULE_21]
            default:     state_next = SIU_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= SIU_IDLE;
        else
            state_reg <= state_next;
    end

    // Ready only when idle; DSB, ISB and WFI stall the issue stage, DMB and WFE only when they drain or sleep
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            req_ready <= 1'b0;
        else
            req_ready <= (state_next == SIU_IDLE); // [RULE_03]
    end

    // Completion pulse for every instruction
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            done <= 1'b0;
        else
            done <= (state_reg != SIU_IDLE || take) && (state_next == SIU_IDLE); // [RULE_12]
    end

    // Fence holds memory issue after a barrier until drained; req_ready is also low while draining, so non-memory ops stall too
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            mem_order_fence <= 1'b0;
        else
            mem_order_fence <= (state_next == SIU_DRAIN); // [RULE_01] [RULE_02]
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pipe_flush <= 1'b0;
        else
            pipe_flush <= (state_reg == SIU_FLUSH); // [RULE_05]
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            svc_raise <= 1'b0;
        else
            svc_raise <= take && (req.op == `SIU_OP_SVC); // [RULE_14]
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            event_out <= 1'b0;
        else
            event_out <= take && (req.op == `SIU_OP_SEV); // [RULE_13]
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            sleeping <= 1'b0;
        else
            sleeping <= (state_next == SIU_SLEEP_I) || (state_next == SIU_SLEEP_E);
    end

    // Event register: set wins over the clear by a wait-for-event
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            event_reg <= 1'b0;
        else if ((take && req.op == `SIU_OP_SEV) || wk.ext_event)
            event_reg <= 1'b1; // [RULE_13]
        else if (WFE_IMPL && take && req.op == `SIU_OP_WFE && event_reg)
            event_reg <= 1'b0; // [RULE_17]
    end

    // Destination write of move-from-special
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gpr_wr.wr_en  <= 1'b0;
            gpr_wr.wr_val <= `SIU_RST_WORD;
        end
        else
        begin
            gpr_wr.wr_en  <= take && (req.op == `SIU_OP_MFS); // [RULE_06]
            gpr_wr.wr_val <= mfs_val;
        end
    end

    // Flags change only by move-to-special on a view carrying them
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            flags <= `SIU_RST_FLAGS;
        else if (take && req.op == `SIU_OP_MTS && has_app_flags(req.spec_sel))
            flags <= req.src_val[`SIU_FLAGS_HI:`SIU_FLAGS_LO]; // [RULE_10] [RULE_11]
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            interrupt_mask_bit <= 1'b0;
        else if (take && req.op == `SIU_OP_IRQ_DISABLE_OP)
            interrupt_mask_bit <= 1'b1; // [RULE_20]
        else if (take && req.op == `SIU_OP_CPSIE)
            interrupt_mask_bit <= 1'b0; // [RULE_20]
        else if (take && req.op == `SIU_OP_MTS && req.spec_sel == `SIU_SR_INTERRUPT_MASK_BIT)
            interrupt_mask_bit <= req.src_val[0]; // [RULE_08]
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            control <= `SIU_RST_CTRL;
        else if (take && req.op == `SIU_OP_MTS && req.spec_sel == `SIU_SR_CONTROL)
            control <= req.src_val[`SIU_CTRL_HI:`SIU_CTRL_LO]; // [RULE_08]
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            main_stack_ptr <= `SIU_RST_WORD;
        else if (take && req.op == `SIU_OP_MTS && req.spec_sel == `SIU_SR_MSP)
            main_stack_ptr <= {req.src_val[31:2], 2'b00}; // [RULE_08]
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            process_stack_ptr <= `SIU_RST_WORD;
        else if (take && req.op == `SIU_OP_MTS && req.spec_sel == `SIU_SR_PSP)
            process_stack_ptr <= {req.src_val[31:2], 2'b00}; // [RULE_08]
    end

endmodule : siu_system_instr_unit

`default_nettype wire

/* verif/siu_far_model.sv */
// Memory system and wake-source model facing the unit
`timescale 1ns/100ps
`default_nettype none
module siu_far_model
(
    input  wire logic          ref_clk,
    input  wire logic          sleeping,
    output logic               mem_outstanding,
    output siu_pkg::siu_wake_t wake_in
);
    import siu_pkg::*;
    initial
    begin
        mem_outstanding = 1'b0;
        wake_in = '0;
    end
    // Earlier accesses stay in flight for n cycles
    task automatic mem_busy(input int n);
        mem_outstanding = 1'b1;
        repeat (n) @(negedge ref_clk);
        mem_outstanding = 1'b0;
    endtask : mem_busy
    // One wake source held until the wait ends or 20 cycles pass
    task automatic wake(input int b);
        wake_in[b] = 1'b1;
        for (int i = 0; i < 20 && sleeping; i++) @(negedge ref_clk);
        wake_in = '0;
    endtask : wake
endmodule : siu_far_model
`default_nettype wire

/* verif/siu_chk_asserts.sv */
// Port-level assertions for the system instruction unit
`include "siu_map.svh"
`timescale 1ns/100ps
`default_nettype none
module siu_chk
(
    input wire logic                ref_clk,
    input wire logic                reset_n,
    input wire siu_pkg::siu_req_t   req,
    input wire logic                mem_outstanding,
    input wire siu_pkg::siu_wake_t  wake_in,
    input wire logic                req_ready,
    input wire logic                done,
    input wire siu_pkg::siu_gpr_wr_t gpr_wr,
    input wire logic                mem_order_fence,
    input wire logic                pipe_flush,
    input wire logic                svc_raise,
    input wire logic                event_out,
    input wire logic                sleeping,
    input wire logic [3:0]          flags,
    input wire logic                interrupt_mask_bit,
    input wire logic [31:0]         main_stack_ptr,
    input wire logic                event_reg
);
    import siu_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_take(logic [3:0] o);
        req.valid && req_ready && req.op == o;
    endsequence
    sequence s_mts(logic [3:0] s);
        s_take(`SIU_OP_MTS) ##0 req.spec_sel == s;
    endsequence
    a_svc_pulse: assert property (s_take(`SIU_OP_SVC) |=> svc_raise && done)
        else $error("svc not raised");
    a_sev_event: assert property (s_take(`SIU_OP_SEV) |=> event_out && event_reg)
        else $error("send event missing");
    a_flags_keep: assert property (req.valid && req_ready && req.op != `SIU_OP_MTS |=> $stable(flags))
        else $error("flags changed");
    a_mts_flags: assert property (s_mts(`SIU_SR_APP_STATUS_VIEW) |=> flags == $past(req.src_val[31:28]))
        else $error("flags not from source");
    a_mts_mask: assert property (s_mts(`SIU_SR_INTERRUPT_MASK_BIT) |=> interrupt_mask_bit == $past(req.src_val[0]))
        else $error("mask not written");
    a_mfs_stack: assert property (s_take(`SIU_OP_MFS) ##0 req.spec_sel == `SIU_SR_MSP
        |=> gpr_wr.wr_en && gpr_wr.wr_val == $past(main_stack_ptr))
        else $error("stack pointer read wrong");
    a_dsb_stall: assert property (s_take(`SIU_OP_DSB) |=> !req_ready && mem_order_fence)
        else $error("sync barrier not stalling");
    a_drain_wait: assert property (mem_order_fence && mem_outstanding |=> !done)
        else $error("barrier done while busy");
    a_isb_flush: assert property (s_take(`SIU_OP_ISB) |-> ##2 pipe_flush && done)
        else $error("no flush");
    a_wfi_sleep: assert property (s_take(`SIU_OP_WFI) |=> sleeping && !req_ready)
        else $error("wait not sleeping");
    a_wake_resume: assert property (sleeping && (wake_in.exc_taken || wake_in.irq_pend_preempt || wake_in.dbg_req)
        |-> ##[1:4] done && !sleeping)
        else $error("wait not woken");
endmodule : siu_chk
bind siu_system_instr_unit siu_chk i_chk (.ref_clk(ref_clk), .reset_n(reset_n), .req(req),
    .mem_outstanding(mem_outstanding), .wake_in(wake_in), .req_ready(req_ready), .done(done), .gpr_wr(gpr_wr),
    .mem_order_fence(mem_order_fence), .pipe_flush(pipe_flush), .svc_raise(svc_raise), .event_out(event_out),
    .sleeping(sleeping), .flags(flags), .interrupt_mask_bit(interrupt_mask_bit),
    .main_stack_ptr(main_stack_ptr), .event_reg(event_reg));
`default_nettype wire

/* verif/siu_system_instr_unit_bench.sv */
// Self-checking bench for the system instruction unit
`include "siu_map.svh"
`timescale 1ns/100ps
`default_nettype none
module siu_system_instr_unit_bench;
    import siu_pkg::*;
    logic ref_clk, reset_n, mem_outstanding, sp_sel_msp, req_ready, done, mem_order_fence;
    logic pipe_flush, svc_raise, event_out, sleeping, interrupt_mask_bit, event_reg;
    logic [5:0] exc_number;
    logic [3:0] flags, pulses;
    logic [1:0] control;
    logic [31:0] main_stack_ptr, process_stack_ptr, rd;
    siu_req_t req;
    siu_wake_t wake_in;
    siu_gpr_wr_t gpr_wr;
    int num_errors, n_compared, lat, cycles;
    logic [3:0] st_sel[4] = '{`SIU_SR_APP_STATUS_VIEW, `SIU_SR_IAPSR, `SIU_SR_EAPSR, `SIU_SR_PSR};
    logic [3:0] rd_sel[5] = '{`SIU_SR_APP_STATUS_VIEW, `SIU_SR_MSP, `SIU_SR_PSP, `SIU_SR_CONTROL, `SIU_SR_EXCEPTION_NUMBER_VIEW};
    logic [31:0] rd_exp[5] = '{32'hc000_0000, 32'h2000_1ff0, 32'h2000_0ff8, 32'h2, 32'hb};
    logic [3:0] misc_op[6] = '{`SIU_OP_NOP, `SIU_OP_WFE, `SIU_OP_SEV, `SIU_OP_SVC, `SIU_OP_DMB, `SIU_OP_ISB};
    int misc_lat[6] = '{1, 1, 1, 1, 1, 2};
    logic [3:0] misc_pls[6] = '{4'h0, 4'h0, 4'h2, 4'h4, 4'h0, 4'h1};
    int wk_bit[3] = '{5, 4, 2};
    siu_system_instr_unit i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .req(req), .mem_outstanding(mem_outstanding),
        .wake_in(wake_in), .exc_number(exc_number), .sp_sel_msp(sp_sel_msp), .req_ready(req_ready), .done(done),
        .gpr_wr(gpr_wr), .mem_order_fence(mem_order_fence), .pipe_flush(pipe_flush), .svc_raise(svc_raise),
        .event_out(event_out), .sleeping(sleeping), .flags(flags), .interrupt_mask_bit(interrupt_mask_bit),
        .control(control), .main_stack_ptr(main_stack_ptr), .process_stack_ptr(process_stack_ptr),
        .event_reg(event_reg));
    siu_far_model i_far (.ref_clk(ref_clk), .sleeping(sleeping), .mem_outstanding(mem_outstanding),
        .wake_in(wake_in));
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            test_done();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Issue one instruction at a falling edge, count edges from take to done
    task automatic exec(input logic [3:0] op, input logic [3:0] sel, input logic [31:0] src);
        // One idle edge between requests keeps valid from toggling twice in a step
        @(negedge ref_clk);
        for (int i = 0; i < 200 && req_ready !== 1'b1; i++) @(negedge ref_clk);
        req = '{1'b1, op, sel, src, src[7:0]};
        lat = 0;
        // Done pulse stands one cycle or more after take; look from the first edge on
        do
        begin
            @(negedge ref_clk);
            lat++;
            req.valid = 1'b0;
        end
        while (done !== 1'b1 && lat < 200);
        pulses = {gpr_wr.wr_en, svc_raise, event_out, pipe_flush};
        rd = gpr_wr.wr_val;
    endtask : exec
    initial
    begin
        req = '0;
        exc_number = 6'h0b;
        sp_sel_msp = 1'b1;
        reset_n = 1'b0;
        repeat (16) @(negedge ref_clk);
        chk("rst_state", 32'h0, {flags, interrupt_mask_bit, event_reg, req_ready, done});
        reset_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("ready", 32'h1, req_ready);
        foreach (st_sel[k])
        begin
            exec(`SIU_OP_MTS, st_sel[k], {4'h9 + k[3:0], 28'h5a5_a5a5});
            chk("mts_flags", 32'h9 + k, flags);
        end
        // Sources and destinations are always general registers
        exec(`SIU_OP_MTS, `SIU_SR_MSP, 32'h2000_1ff0);
        chk("msp", 32'h2000_1ff0, main_stack_ptr);
        exec(`SIU_OP_MTS, `SIU_SR_PSP, 32'h2000_0ff8);
        chk("psp", 32'h2000_0ff8, process_stack_ptr);
        exec(`SIU_OP_MTS, `SIU_SR_CONTROL, 32'h2);
        chk("control", 32'h2, control);
        foreach (rd_sel[k])
        begin
            exec(`SIU_OP_MFS, rd_sel[k], 32'h0);
            chk("mfs_val", rd_exp[k], rd);
            chk("mfs_wr", 32'h8, pulses);
        end
        exec(`SIU_OP_IRQ_DISABLE_OP, 4'h0, 32'h0);
        chk("mask_set", 32'h1, interrupt_mask_bit);
        exec(`SIU_OP_CPSIE, 4'h0, 32'h0);
        chk("mask_clr", 32'h0, interrupt_mask_bit);
        foreach (misc_op[k])
        begin
            exec(misc_op[k], 4'h0, 32'hff);
            chk("misc_flags", 32'hc, flags);
            chk("misc_lat", misc_lat[k], lat);
            chk("misc_pulse", misc_pls[k], pulses);
        end
        chk("event_reg", 32'h1, event_reg);
        fork
            i_far.mem_busy(10);
            exec(`SIU_OP_DSB, 4'h0, 32'h0);
        join
        chk("dsb_wait", 32'h1, lat >= 10);
        fork
            i_far.mem_busy(6);
            exec(`SIU_OP_DMB, 4'h0, 32'h0);
        join
        chk("dmb_wait", 32'h1, lat >= 6);
        exec(`SIU_OP_IRQ_DISABLE_OP, 4'h0, 32'h0);
        foreach (wk_bit[k])
        begin
            fork
                exec(`SIU_OP_WFI, 4'h0, 32'h0);
                begin
                    repeat (8) @(negedge ref_clk);
                    chk("wfi_sleep", 32'h1, sleeping);
                    i_far.wake(wk_bit[k]);
                end
            join
            chk("wfi_resume", 32'h5, {lat >= 8, sleeping, req_ready});
        end
        test_done();
    end
endmodule : siu_system_instr_unit_bench
`default_nettype wire
